// ===== verilog/scp_pkg.sv
// Package for the serial control port: widths, command layout, page select.
// Assumes one 125 MHz system clock; the serial clock is sampled as data.
package scp_pkg;

  // ****************************************************************
  // Widths and command layout
  // ****************************************************************
  localparam int          SCP_DATA_W    = 8;
  localparam int          SCP_IDX_W     = 7;
  localparam int          SCP_CMD_DIR   = 0;
  localparam int          SCP_CMD_IDX_LO = 1;
  localparam int          SCP_CMD_IDX_HI = 7;
  localparam logic [2:0]  SCP_BIT_LAST  = 3'h7;
  localparam logic        SCP_DIR_WRITE = 1'b0;
  localparam logic        SCP_DIR_READ  = 1'b1;

  // ****************************************************************
  // Register space
  // ****************************************************************
  localparam logic [6:0]  SCP_PAGE_IDX  = 7'h00;
  localparam logic [6:0]  SCP_IDX_LAST  = 7'h7f;
  localparam logic [7:0]  SCP_PAGE_RST  = 8'h00;
  localparam logic [7:0]  SCP_REG_RST   = 8'h00;
  localparam int          SCP_PAGES     = 2;
  localparam int          SCP_REGS      = 128;

  // ****************************************************************
  // Timing (host-side spacing, kept for reference by users)
  // ****************************************************************
  localparam real         SCP_CLK_NS    = 8.0;
  localparam real         SCP_GAP_US    = 6.25;
  localparam int          SCP_GAP_CYC   = int'($ceil(SCP_GAP_US * 1000.0 / SCP_CLK_NS));

  // Serial pins, raw or after synchronisation
  typedef struct packed {
    logic sclk;
    logic sel_n;
    logic mosi;
  } scp_pins_t;

  // Register access toward the storage
  typedef struct packed {
    logic       wr;
    logic [7:0] page;
    logic [6:0] idx;
    logic [7:0] wdata;
  } scp_acc_t;

endpackage : scp_pkg

// ===== verilog/scp_sync.sv
// Two-flop synchronisers for the serial pins.
// Assumes pins are asynchronous to clock; the first flop feeds only the second.
`timescale 1ns/1ps
module scp_sync
  import scp_pkg::*;
(
  input  wire logic      clock,   // System clock
  input  wire logic      rst_n,   // Synchronous reset, active low
  input  wire scp_pins_t pins,    // Raw pins
  output scp_pins_t      pins_s   // Synchronised pins
);

  scp_pins_t meta_r;
  scp_pins_t meta_nxt;
  scp_pins_t sync_r;
  scp_pins_t sync_nxt;

  always_comb begin
    meta_nxt = pins;
    sync_nxt = meta_r;
    if (!rst_n) begin
      // Idle levels: clock low, frame deselected
      meta_nxt = '{sclk: 1'b0, sel_n: 1'b1, mosi: 1'b0};
      sync_nxt = '{sclk: 1'b0, sel_n: 1'b1, mosi: 1'b0};
    end
  end

  always_ff @(posedge clock) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign pins_s = sync_r;

endmodule : scp_sync

// ===== verilog/scp_port.sv
// Serial control port slave with two pages of 8-bit control registers.
// Assumes the host is the bus master, mode 1 timing, frame select low-active;
// the register contents are exported for the rest of the device.
// Pins are asynchronous and pass two flops before any decoding.
`timescale 1ns/1ps

// Behaviour
// - Serial protocol only while select pin high
// - Serial clock idles low
// - Drive on first edge, sample second
// - Shift out while shifting in
// - First byte command; data only writes
// - Realign at frame select fall and rise
// - Index bits 7..1, direction bit 0
// - Direction 0: store following byte
// - Direction 1: return register, second byte
// - Burst write steps index upward
// - Burst read steps index upward
// - Frame select rise ends frame, burst
// - Index zero selects page, resets zero
// - Registers eight bits, bit 7 first
module scp_port
  import scp_pkg::*;
(
  input  wire logic             clock,                   // System clock, 125 MHz
  input  wire logic             rst_n,                   // Synchronous reset, active low
  input  wire logic             protocol_select,         // High selects serial protocol
  input  wire logic             frame_select_n,          // Frame select pin, active low
  input  wire logic             multifunction_pin_one,   // Serial clock pin
  input  wire logic             multifunction_pin_three, // Serial data from host
  output logic                  multifunction_pin_two,   // Serial data to host
  output logic                  miso_oe_n,               // Data-out enable, low drives
  output logic [7:0]            page_r,                  // Active page
  output logic [SCP_PAGES*SCP_REGS*SCP_DATA_W-1:0] regs_flat // All register bits
);

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  scp_pins_t pins_raw;
  scp_pins_t pins_s;
  scp_pins_t prev_r;
  scp_pins_t prev_nxt;

  assign pins_raw = '{sclk: multifunction_pin_one, sel_n: frame_select_n,
                      mosi: multifunction_pin_three};

  scp_sync u_sync (
    .clock  (clock),
    .rst_n  (rst_n),
    .pins   (pins_raw),
    .pins_s (pins_s)
  );

  logic proto_m_r;
  logic proto_m_nxt;
  logic proto_r;
  logic proto_nxt;
  logic enable;
  logic sel_fall;
  logic sel_rise;
  logic sclk_rise;
  logic sclk_fall;

  assign enable    = proto_r;
  assign sel_fall  = enable &&  prev_r.sel_n && !pins_s.sel_n;
  assign sel_rise  = !prev_r.sel_n && pins_s.sel_n;
  assign sclk_rise = enable && !pins_s.sel_n && !prev_r.sclk &&  pins_s.sclk;
  assign sclk_fall = enable && !pins_s.sel_n &&  prev_r.sclk && !pins_s.sclk;

  always_comb begin
    prev_nxt = rst_n ? pins_s : '{sclk: 1'b0, sel_n: 1'b1, mosi: 1'b0};
  end

  always_ff @(posedge clock) begin
    prev_r <= prev_nxt;
  end

  // ****************************************************************
  // Protocol select synchroniser
  // ****************************************************************
  // The select pin is meant to stay static; two flops still guard
  // against an edge landing close to the clock
  always_comb begin
    proto_m_nxt = rst_n ? protocol_select : 1'b0;
    proto_nxt   = rst_n ? proto_m_r : 1'b0;
  end

  always_ff @(posedge clock) begin
    proto_m_r <= proto_m_nxt;
    proto_r   <= proto_nxt;
  end

  // ****************************************************************
  // Frame state
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD  = 3'b010,
    ST_DATA = 3'b100
  } scp_state_t;

  scp_state_t       state_r;
  scp_state_t       state_nxt;
  logic [2:0]       bit_r;
  logic [2:0]       bit_nxt;
  logic [7:0]       shin_r;
  logic [7:0]       shin_nxt;
  logic [7:0]       shout_r;
  logic [7:0]       shout_nxt;
  logic [6:0]       idx_r;
  logic [6:0]       idx_nxt;
  logic             dir_r;
  logic             dir_nxt;
  logic             oe_n_r;
  logic             oe_n_nxt;
  logic             byte_done;
  logic [7:0]       page_nxt;
  scp_acc_t         acc;
  logic [7:0]       rd_data;
  logic [7:0]       rd_next;
  logic [7:0]       byte_in;

  // ****************************************************************
  // Read data lookup
  // ****************************************************************
  // Storage: two pages, index 0 of each page reads back as the page selector
  logic [7:0] mem_r [SCP_PAGES][SCP_REGS];

  function automatic logic [7:0] reg_rd(input logic [7:0] pg, input logic [6:0] ix);
    logic [7:0] v;
    v = SCP_REG_RST;
    if (ix == SCP_PAGE_IDX) begin
      v = page_r;
    end else begin
      v = mem_r[pg[0]][ix];
    end
    return v;
  endfunction : reg_rd

  assign byte_in = {shin_r[6:0], pins_s.mosi};
  assign rd_data = reg_rd(page_r, byte_in[SCP_CMD_IDX_HI:SCP_CMD_IDX_LO]);
  assign rd_next = reg_rd(page_r, idx_r + 7'h01);

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  // Eighth sampled bit closes a byte
  assign byte_done = sclk_fall && (bit_r == SCP_BIT_LAST);

  always_comb begin
    state_nxt = state_r;
    bit_nxt   = bit_r;
    shin_nxt  = shin_r;
    shout_nxt = shout_r;
    idx_nxt   = idx_r;
    dir_nxt   = dir_r;
    oe_n_nxt  = oe_n_r;
    page_nxt  = page_r;
    acc       = '{wr: 1'b0, page: page_r, idx: idx_r, wdata: byte_in};
    if (sel_fall) begin
      state_nxt = ST_CMD;
      bit_nxt   = 3'h0;
      shout_nxt = 8'h00;
      oe_n_nxt  = 1'b0;
    end else if (sel_rise || !enable) begin
      state_nxt = ST_IDLE;
      bit_nxt   = 3'h0;
      oe_n_nxt  = 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_CMD, ST_DATA: begin
          if (sclk_fall) begin
            shin_nxt = byte_in;
            bit_nxt  = bit_r + 3'h1;
            if (byte_done) begin
              if (state_r == ST_CMD) begin
                idx_nxt   = byte_in[SCP_CMD_IDX_HI:SCP_CMD_IDX_LO];
                dir_nxt   = byte_in[SCP_CMD_DIR];
                state_nxt = ST_DATA;
                // Load read data for next byte
                shout_nxt = (byte_in[SCP_CMD_DIR] == SCP_DIR_READ) ? rd_data : 8'h00;
              end else if (dir_r == SCP_DIR_WRITE) begin
                acc.wr  = 1'b1;
                // Seven-bit index wraps; the host must stop at the page end
                // Next write goes one higher
                idx_nxt = idx_r + 7'h01;
                if (idx_r == SCP_PAGE_IDX) begin
                  page_nxt = byte_in;
                end
              end else begin
                idx_nxt   = idx_r + 7'h01;
                shout_nxt = rd_next;
              end
            end
          end else if (sclk_rise && bit_r != 3'h0) begin
            shout_nxt = {shout_r[6:0], 1'b0};
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
    // Reset wins over any frame event
    if (!rst_n) begin
      state_nxt = ST_IDLE;
      bit_nxt   = 3'h0;
      shin_nxt  = 8'h00;
      shout_nxt = 8'h00;
      idx_nxt   = 7'h00;
      dir_nxt   = SCP_DIR_WRITE;
      oe_n_nxt  = 1'b1;
      page_nxt  = SCP_PAGE_RST;
      acc.wr    = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    state_r <= state_nxt;
    bit_r   <= bit_nxt;
    shin_r  <= shin_nxt;
    shout_r <= shout_nxt;
    idx_r   <= idx_nxt;
    dir_r   <= dir_nxt;
    oe_n_r  <= oe_n_nxt;
    page_r  <= page_nxt;
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  // Index 0 cells are written per page but never read back: page_r is the single selector
  genvar gp, gi;
  generate
    for (gp = 0; gp < SCP_PAGES; gp++) begin : g_page
      for (gi = 0; gi < SCP_REGS; gi++) begin : g_reg
        logic [7:0] cell_nxt;
        logic       cell_hit;
        // One decoder per cell keeps the write fan-in local
        assign cell_hit = acc.wr && (acc.page[0] == 1'(gp)) && (acc.idx == 7'(gi));
        always_comb begin
          cell_nxt = mem_r[gp][gi];
          if (!rst_n) begin
            cell_nxt = SCP_REG_RST;
          end else if (cell_hit) begin
            cell_nxt = acc.wdata;
          end
        end
        always_ff @(posedge clock) begin
          mem_r[gp][gi] <= cell_nxt;
        end
        // Index 0 slices mirror the shared selector
        assign regs_flat[(gp*SCP_REGS+gi)*SCP_DATA_W +: SCP_DATA_W] =
          (gi == 0) ? page_r : mem_r[gp][gi];
      end
    end
  endgenerate

  // ****************************************************************
  // Data out
  // ****************************************************************
  // Registered from the next-state values, so the pin moves with shout_r
  // and carries no glitch from the enable mux
  logic out_r;
  logic out_nxt;

  // First bit valid before the first clock edge of the byte
  always_comb begin
    out_nxt = oe_n_nxt ? 1'b0 : shout_nxt[7];
  end

  always_ff @(posedge clock) begin
    out_r <= out_nxt;
  end

  assign multifunction_pin_two = out_r;
  assign miso_oe_n             = oe_n_r;

endmodule : scp_port

// ===== tb/scp_port_properties.sv
// Checker for the serial control port, bound to every scp_port.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module scp_port_props
  import scp_pkg::*;
(
  input wire logic       clock,                   // System clock
  input wire logic       rst_n,                   // Reset, active low
  input wire logic       protocol_select,         // Protocol choice
  input wire logic       frame_select_n,          // Frame select
  input wire logic       multifunction_pin_one,   // Serial clock
  input wire logic       multifunction_pin_three, // Data from host
  input wire logic       multifunction_pin_two,   // Data to host
  input wire logic       miso_oe_n,               // Data-out enable
  input wire logic [7:0] page_r,                  // Active page
  input wire logic [SCP_PAGES*SCP_REGS*SCP_DATA_W-1:0] regs_flat // Registers
);
  // ****************************************************************
  // Sequences and properties
  // ****************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Eight cycles cover the pin synchronisers with margin
  sequence s_idle; frame_select_n [*8]; endsequence
  sequence s_off; !protocol_select [*8]; endsequence
  sequence s_frame; (protocol_select && !frame_select_n) [*8]; endsequence
  sequence s_clk_high; multifunction_pin_one [*6]; endsequence

  a_oe_idle_off: assert property (s_idle |-> miso_oe_n)
    else $error("data out driven outside a frame");
  a_oe_port_off: assert property (s_off |-> miso_oe_n)
    else $error("data out driven while port disabled");
  a_oe_in_frame: assert property (s_frame |-> !miso_oe_n)
    else $error("data out not driven in a frame");
  a_out_bit_hold: assert property (s_clk_high |=> $stable(multifunction_pin_two))
    else $error("data out moved late in clock high phase");
  a_regs_idle_quiet: assert property (s_idle |=> $stable(regs_flat) && $stable(page_r))
    else $error("registers changed outside a frame");
  a_page_zero_mirror: assert property (regs_flat[7:0] == page_r &&
    regs_flat[SCP_REGS*SCP_DATA_W +: 8] == page_r)
    else $error("index zero differs from page");
  a_page_in_frame: assert property ($changed(page_r) |-> !frame_select_n)
    else $error("page changed outside a frame");
  a_page_reset_val: assert property ($rose(rst_n) |-> page_r == SCP_PAGE_RST)
    else $error("page not cleared by reset");
  a_regs_reset_val: assert property ($rose(rst_n) |-> regs_flat == '0)
    else $error("registers not cleared by reset");
endmodule : scp_port_props

bind scp_port scp_port_props scp_port_props_inst (
  .clock(clock), .rst_n(rst_n), .protocol_select(protocol_select),
  .frame_select_n(frame_select_n), .multifunction_pin_one(multifunction_pin_one),
  .multifunction_pin_three(multifunction_pin_three),
  .multifunction_pin_two(multifunction_pin_two), .miso_oe_n(miso_oe_n),
  .page_r(page_r), .regs_flat(regs_flat));

// ===== tb/scp_host.sv
// Host model: serial master with a 160 ns clock, mode 1 timing.
// Assumes the caller fills tx before run and reads rx after it.
`timescale 1ns/1ps
module scp_host
  import scp_pkg::*;
(
  output logic      sclk,   // Serial clock
  output logic      sel_n,  // Frame select
  output logic      mosi,   // Data to device
  input  wire logic miso    // Data from device
);
  logic [7:0] tx [16];
  logic [7:0] rx [16];
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b1;
  end
  // master clocks frames, drives on first edge
  task automatic run(input int nbits);
    sel_n = 1'b0;
    #160;
    for (int k = 0; k < nbits; k++) begin
      sclk = 1'b1;
      mosi = tx[k/8][7-k%8];
      #80;
      sclk = 1'b0;
      rx[k/8][7-k%8] = miso;
      #80;
    end
    #80;
    sel_n = 1'b1;
    // Released line shows the inverse so stale data cannot pass
    mosi = ~mosi;
    #(SCP_GAP_CYC * SCP_CLK_NS);
  endtask : run
endmodule : scp_host

// ===== tb/test_spi_register_control_port.sv
// Self-checking bench for scp_port with a host master model.
// Assumes 125 MHz clock; expected registers kept in a local copy.
`timescale 1ns/1ps
module test_spi_register_control_port;
  import scp_pkg::*;
  localparam int W = SCP_PAGES*SCP_REGS*SCP_DATA_W;
  logic         clock = 1'b0;
  logic         rst_n = 1'b0;
  logic         protocol_select = 1'b1;
  wire          sclk, sel_n, mosi, miso;
  logic         miso_oe_n;
  logic [7:0]   page_r, pg;
  logic [W-1:0] regs_flat;
  logic [7:0]   mem [2][128];
  int           n_errors = 0, num_checks = 0, seed = 22536;

  always #4 clock = ~clock;
  scp_host scp_host_inst (.sclk(sclk), .sel_n(sel_n), .mosi(mosi), .miso(miso));
  scp_port scp_port_inst (.clock(clock), .rst_n(rst_n), .protocol_select(protocol_select),
    .frame_select_n(sel_n), .multifunction_pin_one(sclk), .multifunction_pin_three(mosi),
    .multifunction_pin_two(miso), .miso_oe_n(miso_oe_n), .page_r(page_r),
    .regs_flat(regs_flat));

  // ****************************************************************
  // Expectations and checks
  // ****************************************************************
  function automatic logic [7:0] get(input logic [6:0] i);
    return (i == 7'h00) ? pg : mem[pg[0]][i];
  endfunction : get
  function automatic logic [W-1:0] flat();
    logic [W-1:0] v;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 128; i++)
        v[(p*128+i)*8 +: 8] = (i == 0) ? pg : mem[p][i];
    return v;
  endfunction : flat
  task automatic check(input string name, input logic [W-1:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic frame(input logic [6:0] idx, input logic dir, input int n, input logic [7:0] d0);
    @(posedge clock);
    #1;
    scp_host_inst.tx[0] = {idx, dir};
    for (int k = 1; k <= n; k++) scp_host_inst.tx[k] = (k == 1) ? d0 : 8'($random(seed));
    scp_host_inst.run(8*(n+1));
    for (int k = 1; k <= n; k++) begin
      if (dir == SCP_DIR_READ)
        check("read", W'(scp_host_inst.rx[k]), W'(get(idx+7'(k-1))));
      else if (protocol_select && idx+7'(k-1) == 7'h00) pg = scp_host_inst.tx[k];
      else if (protocol_select) mem[pg[0]][idx+7'(k-1)] = scp_host_inst.tx[k];
    end
    check("regs", regs_flat, flat());
    check("page", W'(page_r), W'(pg));
  endtask : frame
  task automatic do_reset();
    rst_n = 1'b0;
    pg = SCP_PAGE_RST;
    foreach (mem[p, i]) mem[p][i] = SCP_REG_RST;
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clock);
    check("reset", regs_flat, flat());
  endtask : do_reset

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    #600000;
    n_errors++;
    summarize();
  end
  initial begin
    logic [6:0] a;
    do_reset();
    for (int t = 0; t < 6; t++) begin
      a = 7'($unsigned($random(seed)) % 127 + 1);
      frame(a, SCP_DIR_WRITE, 1, 8'($random(seed)));
      frame(a, SCP_DIR_READ, 1, 8'($random(seed)));
    end
    $display("test random single done");
    for (int p = 1; p >= 0; p--) begin
      frame(7'h00, SCP_DIR_WRITE, 1, 8'(p));
      frame(7'h09, SCP_DIR_WRITE, 1, 8'($random(seed)));
      frame(7'h00, SCP_DIR_READ, 2, 8'h5a);
    end
    $display("test page select done");
    frame(7'h7d, SCP_DIR_WRITE, 3, 8'h80);
    frame(7'h7c, SCP_DIR_READ, 4, 8'hff);
    $display("test burst boundary done");
    // A cut command must not shift the next frame
    scp_host_inst.tx[0] = 8'h0b;
    scp_host_inst.run(5);
    frame(7'h03, SCP_DIR_WRITE, 1, 8'h3c);
    $display("test realign done");
    protocol_select = 1'b0;
    repeat (4) @(posedge clock);
    frame(7'h0b, SCP_DIR_WRITE, 1, 8'ha5);
    protocol_select = 1'b1;
    repeat (4) @(posedge clock);
    $display("test port disabled done");
    do_reset();
    frame(7'h0b, SCP_DIR_READ, 1, 8'h00);
    $display("test second reset done");
    summarize();
  end
endmodule : test_spi_register_control_port
